// *** design/adc_capture_sequencer.sv ***
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Snap collects programmed count, then stops
// - Start repeats records, back to back in immediate mode, re-arming for each record in triggered mode
// - Stop finishes current record, then halts
// - Defaults: immediate start, test pattern off
// - Triggered mode waits for selected event edge
// - Missing edge abandons capture, reports timeout
// - Test pattern replaces input, same start rules
// - Low-code pattern gives code zero
// - High-code pattern gives code 4095
// - Align pattern runs, period 32 samples
// - Defaults: linearity correction disabled
// - Correction change applies from next record
// - Toggle command turns correction on, or off again
// - Restore-defaults returns all settings
// - Revision identifiers readable by host
//////////////////////////////////////////////////////////////////////////////
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module adc_capture_sequencer
    import capture_pkg::*;
#(
    parameter int MAX_LOG2 = 16,
    parameter int LUT_AW = 12,
    // Identification values are arbitrary
    parameter logic [31:0] REV_CONVERTER = 32'h0000_0001,
    parameter logic [31:0] REV_FIRMWARE = 32'h0000_0002,
    parameter logic [31:0] REV_LOGIC = 32'h0000_0003
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [SAMPLE_W-1:0] adc_data,
    input wire logic event_in,
    output logic record_done,
    output logic capturing
);
    localparam logic [MAX_LOG2:0] COUNT_RESET = (MAX_LOG2+1)'(1) << 8;

    function automatic logic is_pow2(input logic [31:0] v);
        is_pow2 = (v != 32'h0) && ((v & (v - 32'h1)) == 32'h0);
    endfunction : is_pow2

    //////////////////////////////////////////////////////////////////////////
    // Register state
    logic [5:0] ctrl_r;
    logic [MAX_LOG2:0] count_r;
    logic [31:0] timeout_r;
    logic [LUT_AW-1:0] lut_addr_r;
    logic [MAX_LOG2-1:0] rec_addr_r;
    logic [SAMPLE_W-1:0] lut_mem [0:(1<<LUT_AW)-1];
    logic [SAMPLE_W-1:0] rec_mem [0:(1<<MAX_LOG2)-1];
    logic [SAMPLE_W-1:0] rec_q_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic done_r;
    logic timeout_flag_r;
    logic badcnt_r;
    logic cont_r;
    logic stop_req_r;
    logic corr_active_r;
    logic event_d_r;
    logic record_done_r;
    logic capturing_r;
    seq_state_t state_r;
    logic [MAX_LOG2:0] sample_cnt_r;
    logic [31:0] wait_cnt_r;

    //////////////////////////////////////////////////////////////////////////
    // APB decode
    wire logic setup = psel && !penable;
    wire logic wr_setup = setup && pwrite;
    wire logic hit_ctrl = paddr == OFS_CTRL;
    wire logic hit_cmd = paddr == OFS_CMD;
    wire logic hit_count = paddr == OFS_COUNT;
    wire logic hit_tmo = paddr == OFS_TIMEOUT;
    wire logic hit_laddr = paddr == OFS_LUT_ADDR;
    wire logic hit_ldata = paddr == OFS_LUT_DATA;
    wire logic hit_raddr = paddr == OFS_REC_ADDR;
    wire logic hit_rdata = paddr == OFS_REC_DATA;
    wire logic hit_status = paddr == OFS_STATUS;
    wire logic hit_rev = (paddr == OFS_REV_CONV) || (paddr == OFS_REV_FW) ||
                         (paddr == OFS_REV_LOGIC);
    wire logic mapped = hit_ctrl || hit_cmd || hit_count || hit_tmo || hit_laddr ||
                        hit_ldata || hit_raddr || hit_rdata || hit_status || hit_rev;

    wire logic cmd_wr = wr_setup && hit_cmd;
    wire logic cmd_snap = cmd_wr && pwdata[CMD_SNAP_BIT];
    wire logic cmd_start = cmd_wr && pwdata[CMD_START_BIT];
    wire logic cmd_stop = cmd_wr && pwdata[CMD_STOP_BIT];
    wire logic cmd_defaults = cmd_wr && pwdata[CMD_DEFAULTS_BIT];
    wire logic cmd_toggle = cmd_wr && pwdata[CMD_CORR_TOGGLE_BIT];
    wire logic cmd_go = (cmd_snap || cmd_start) && (state_r == ST_IDLE);
    wire logic count_ok = is_pow2(pwdata) && (pwdata <= 32'(1 << MAX_LOG2));

    wire logic [31:0] status_word = {25'h0, badcnt_r, corr_active_r, cont_r,
                                     timeout_flag_r, done_r, state_r == ST_ARMED,
                                     state_r != ST_IDLE};
    wire logic [31:0] rd_word =
        hit_ctrl ? {26'h0, ctrl_r} :
        hit_status ? status_word :
        hit_count ? 32'(count_r) :
        hit_tmo ? timeout_r :
        hit_laddr ? 32'(lut_addr_r) :
        hit_raddr ? 32'(rec_addr_r) :
        hit_rdata ? 32'(rec_q_r) :
        (paddr == OFS_REV_CONV) ? REV_CONVERTER :
        (paddr == OFS_REV_FW) ? REV_FIRMWARE :
        (paddr == OFS_REV_LOGIC) ? REV_LOGIC : 32'h0;

    // Slave answers one cycle after setup; pready is registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r <= (setup && !pwrite) ? rd_word : 32'h0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Settings
    always_ff @(posedge ref_clk) begin
        if (rst || cmd_defaults) begin
            ctrl_r <= CTRL_RESET;
            count_r <= COUNT_RESET;
            timeout_r <= TIMEOUT_RESET;
            badcnt_r <= 1'b0;
        end else begin
            if (wr_setup && hit_ctrl) begin
                ctrl_r <= pwdata[5:0];
            end else if (cmd_toggle) begin
                ctrl_r[CTRL_CORR_BIT] <= !ctrl_r[CTRL_CORR_BIT];
            end
            if (wr_setup && hit_count) begin
                badcnt_r <= !count_ok;
                if (count_ok) begin
                    count_r <= pwdata[MAX_LOG2:0];
                end
            end
            if (wr_setup && hit_tmo) begin
                timeout_r <= pwdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lut_addr_r <= '0;
            rec_addr_r <= '0;
        end else begin
            if (wr_setup && hit_laddr) begin
                lut_addr_r <= pwdata[LUT_AW-1:0];
            end else if (wr_setup && hit_ldata) begin
                lut_addr_r <= lut_addr_r + 1'b1;
            end
            if (wr_setup && hit_raddr) begin
                rec_addr_r <= pwdata[MAX_LOG2-1:0];
            end else if (setup && !pwrite && hit_rdata) begin
                rec_addr_r <= rec_addr_r + 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sample path
    // Phase restarts on every record so short records still open on the first word
    wire logic rec_end = sample_cnt_r == count_r - 1'b1;
    wire logic pat_restart = (state_r != ST_CAPTURE) || rec_end;
    logic [SAMPLE_W-1:0] pat_code;
    pattern_source u_pattern (
        .ref_clk(ref_clk),
        .rst(rst),
        .restart(pat_restart),
        .pattern_sel(ctrl_r[CTRL_PAT_HI:CTRL_PAT_LO]),
        .code(pat_code)
    );

    wire logic [SAMPLE_W-1:0] raw_code = ctrl_r[CTRL_TEST_BIT] ? pat_code : adc_data;
    wire logic [SAMPLE_W-1:0] lut_code = lut_mem[raw_code[LUT_AW-1:0]];
    wire logic [SAMPLE_W-1:0] sample = corr_active_r ? lut_code : raw_code;

    always_ff @(posedge ref_clk) begin
        if (wr_setup && hit_ldata) begin
            lut_mem[lut_addr_r] <= pwdata[SAMPLE_W-1:0];
        end
        if (state_r == ST_CAPTURE) begin
            rec_mem[sample_cnt_r[MAX_LOG2-1:0]] <= sample;
        end
        rec_q_r <= rec_mem[rec_addr_r];
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    wire logic edge_rise = event_in && !event_d_r;
    wire logic edge_fall = !event_in && event_d_r;
    wire logic trig_hit = ctrl_r[CTRL_EDGE_BIT] ? edge_rise : edge_fall;
    wire logic last_sample = rec_end;
    wire logic tmo_hit = wait_cnt_r >= timeout_r;
    // Immediate mode skips arming; triggered mode arms first
    wire logic begin_arm = ctrl_r[CTRL_TRIG_BIT];
    // A stop in the last cycle of a record still counts for that record
    wire logic go_on = cont_r && !stop_req_r && !cmd_stop;
    wire logic keep_capture = !last_sample || (go_on && !begin_arm);
    // Capture flag gets its own flop so the pin is not decoded from the state
    wire logic capture_nxt =
        (state_r == ST_IDLE) ? (cmd_go && !begin_arm) :
        (state_r == ST_ARMED) ? trig_hit :
        (state_r == ST_CAPTURE) ? keep_capture : 1'b0;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            sample_cnt_r <= '0;
            wait_cnt_r <= 32'h0;
            cont_r <= 1'b0;
            stop_req_r <= 1'b0;
            corr_active_r <= 1'b0;
            done_r <= 1'b0;
            timeout_flag_r <= 1'b0;
            event_d_r <= 1'b0;
            record_done_r <= 1'b0;
            capturing_r <= 1'b0;
        end else begin
            event_d_r <= event_in;
            record_done_r <= 1'b0;
            capturing_r <= capture_nxt;
            if (cmd_stop && cont_r) begin
                stop_req_r <= 1'b1;
            end
            case (state_r)
                ST_IDLE: begin
                    if (cmd_go) begin
                        cont_r <= cmd_start;
                        stop_req_r <= 1'b0;
                        done_r <= 1'b0;
                        timeout_flag_r <= 1'b0;
                        corr_active_r <= ctrl_r[CTRL_CORR_BIT];
                        sample_cnt_r <= '0;
                        wait_cnt_r <= 32'h0;
                        state_r <= begin_arm ? ST_ARMED : ST_CAPTURE;
                    end
                end
                ST_ARMED: begin
                    wait_cnt_r <= wait_cnt_r + 32'h1;
                    if (trig_hit) begin
                        state_r <= ST_CAPTURE;
                    end else if (tmo_hit) begin
                        timeout_flag_r <= 1'b1;
                        cont_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_CAPTURE: begin
                    sample_cnt_r <= sample_cnt_r + 1'b1;
                    if (last_sample) begin
                        done_r <= 1'b1;
                        record_done_r <= 1'b1;
                        sample_cnt_r <= '0;
                        wait_cnt_r <= 32'h0;
                        // Latest correction choice takes hold at record boundary
                        corr_active_r <= ctrl_r[CTRL_CORR_BIT];
                        if (go_on) begin
                            state_r <= begin_arm ? ST_ARMED : ST_CAPTURE;
                        end else begin
                            cont_r <= 1'b0;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign record_done = record_done_r;
    assign capturing = capturing_r;
endmodule : adc_capture_sequencer
`default_nettype wire

// *** design/capture_pkg.sv ***
package capture_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_TIMEOUT = 8'h10;
    localparam logic [7:0] OFS_LUT_ADDR = 8'h14;
    localparam logic [7:0] OFS_LUT_DATA = 8'h18;
    localparam logic [7:0] OFS_REC_ADDR = 8'h1C;
    localparam logic [7:0] OFS_REC_DATA = 8'h20;
    localparam logic [7:0] OFS_REV_CONV = 8'h24;
    localparam logic [7:0] OFS_REV_FW = 8'h28;
    localparam logic [7:0] OFS_REV_LOGIC = 8'h2C;

    // CTRL fields
    localparam int CTRL_TRIG_BIT = 0;
    localparam int CTRL_EDGE_BIT = 1;
    localparam int CTRL_TEST_BIT = 2;
    localparam int CTRL_PAT_LO = 3;
    localparam int CTRL_PAT_HI = 4;
    localparam int CTRL_CORR_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // CMD bits, write-one pulses
    localparam int CMD_SNAP_BIT = 0;
    localparam int CMD_START_BIT = 1;
    localparam int CMD_STOP_BIT = 2;
    localparam int CMD_DEFAULTS_BIT = 3;
    localparam int CMD_CORR_TOGGLE_BIT = 4;

    // STATUS fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_TIMEOUT_BIT = 3;
    localparam int STAT_CONT_BIT = 4;
    localparam int STAT_CORR_BIT = 5;
    localparam int STAT_BADCNT_BIT = 6;

    localparam int SAMPLE_W = 12;
    localparam logic [11:0] CODE_LOW = 12'h000;
    localparam logic [11:0] CODE_HIGH = 12'hFFF;
    localparam int ALIGN_PERIOD = 32;
    localparam logic [31:0] ALIGN_WORD = 32'hCCCC_F0FF;
    localparam logic [31:0] TIMEOUT_RESET = 32'h0001_0000;

    typedef enum logic [1:0] {
        PAT_LOW = 2'b00,
        PAT_HIGH = 2'b01,
        PAT_ALIGN = 2'b10,
        PAT_ALIGN2 = 2'b11
    } pattern_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_CAPTURE = 2'b10
    } seq_state_t;
endpackage : capture_pkg

// *** design/pattern_source.sv ***
`timescale 1ns/1ns
`default_nettype none
module pattern_source
    import capture_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [1:0] pattern_sel,
    output logic [SAMPLE_W-1:0] code
);
    logic [4:0] phase_r;
    wire logic align_bit = ALIGN_WORD[phase_r];
    wire logic [SAMPLE_W-1:0] align_code = align_bit ? CODE_HIGH : CODE_LOW;

    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            phase_r <= 5'h00;
        end else begin
            phase_r <= phase_r + 5'h01;
        end
    end

    // Align pattern repeats every 32 samples from the record start
    assign code = (pattern_sel == PAT_LOW) ? CODE_LOW :
                  (pattern_sel == PAT_HIGH) ? CODE_HIGH :
                  align_code;
endmodule : pattern_source
`default_nettype wire

// *** tb/adc_capture_sequencer_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_capture_sequencer_checker
    import capture_pkg::*;
#(
    parameter logic [31:0] REV_CONVERTER = 32'h0000_0001
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic record_done,
    input wire logic capturing
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic setup = psel && !penable;
    a_ready_after_setup: assert property (setup |=> pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero while idle");
    a_unmapped_err: assert property (setup && paddr > OFS_REV_LOGIC |=> pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (setup && paddr <= OFS_REV_LOGIC |=> !pslverr)
        else $error("mapped access refused");
    a_rev_read: assert property (
        setup && !pwrite && paddr == OFS_REV_CONV |=> prdata == REV_CONVERTER)
        else $error("converter revision wrong");
    a_done_after_cap: assert property (record_done |-> $past(capturing))
        else $error("record done without capture");
    a_stop_with_done: assert property ($fell(capturing) |-> record_done)
        else $error("capture ended without record");
    c_record: cover property (record_done);
    c_refused: cover property (pslverr);
    c_capture: cover property ($rose(capturing));
endmodule : adc_capture_sequencer_checker
bind adc_capture_sequencer adc_capture_sequencer_checker #(.REV_CONVERTER(REV_CONVERTER)) chk (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .record_done(record_done), .capturing(capturing));
`default_nettype wire

// *** tb/adc_capture_sequencer_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_capture_sequencer_test
    import capture_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic event_in = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic record_done;
    logic capturing;
    logic [SAMPLE_W-1:0] adc_data;
    logic [64:0] apb_q[$];
    logic [64:0] e;
    logic [31:0] lut_v;
    int done_q[$];
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int cap_cnt = 0;
    logic [7:0] ra[8] = '{OFS_CTRL, OFS_STATUS, OFS_COUNT, OFS_TIMEOUT,
        OFS_REV_CONV, OFS_REV_FW, OFS_REV_LOGIC, 8'h30};
    logic [31:0] rv[8] = '{32'h0, 32'h0, 32'h100, TIMEOUT_RESET, 32'h1, 32'h2, 32'h3, 32'h0};
    adc_model conv (.ref_clk(ref_clk), .rst(rst), .adc_data(adc_data));
    adc_capture_sequencer dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_data(adc_data), .event_in(event_in),
        .record_done(record_done), .capturing(capturing));
    always #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Expectation is queued before the request; the monitor judges it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m, input logic [31:0] x);
        apb_q.push_back({a > OFS_REV_LOGIC, m, x});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only pready or the bench timeout ends this wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0, m, x);
    endtask : rd
    task automatic wait_done(input int left);
        int n;
        n = 0;
        while (done_q.size() > left && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        check("record wait", 32'(n == 3000), 32'h0);
    endtask : wait_done
    // Pattern 4 stands for a fixed expected code c
    task automatic rec_chk(input int cnt, input int p, input logic [31:0] c);
        wr(OFS_REC_ADDR, 32'h0);
        rd(OFS_REC_ADDR, 32'h0, 32'hFFFF);
        for (int k = 0; k < cnt; k++) begin
            rd(OFS_REC_DATA, p > 3 ? c : p == 0 ? 32'h0 : p == 1 ? 32'hFFF :
                (ALIGN_WORD[k % ALIGN_PERIOD] ? 32'hFFF : 32'h0), 32'hFFF);
        end
    endtask : rec_chk
    task automatic snap(input int cnt);
        done_q.push_back(cnt);
        wr(OFS_CMD, 32'h1);
    endtask : snap
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    always @(posedge ref_clk) begin
        if (pready === 1'b1) begin
            e = apb_q.pop_front();
            check("prdata", prdata & e[63:32], e[31:0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, e[64]});
        end
        if (record_done === 1'b1) begin
            check("record length", 32'(cap_cnt), 32'(done_q.pop_front()));
            cap_cnt = capturing === 1'b1 ? 1 : 0;
        end else if (capturing === 1'b1) begin
            cap_cnt++;
        end
    end
    initial begin
        void'($urandom(32'hC5AA));
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (ra[i]) rd(ra[i], rv[i], 32'hFFFF_FFFF);
        wr(OFS_COUNT, 32'h3);
        rd(OFS_STATUS, 32'h40, 32'h40);
        rd(OFS_COUNT, 32'h100, 32'hFFFF_FFFF);
        $display("test reset and registers done");
        wr(OFS_COUNT, 32'h20);
        for (int p = 0; p < 4; p++) begin
            wr(OFS_CTRL, 32'(4 + (p << 3)));
            snap(32);
            wait_done(0);
            rec_chk(32, p, 32'h0);
        end
        $display("test patterns done");
        wr(OFS_CTRL, 32'hC);
        lut_v = {20'h0, 12'($urandom)};
        wr(OFS_LUT_ADDR, 32'hFFF);
        wr(OFS_LUT_DATA, lut_v);
        snap(32);
        wr(OFS_CMD, 32'h10);
        wait_done(0);
        rec_chk(32, 1, 32'h0);
        rd(OFS_STATUS, 32'h20, 32'h20);
        snap(32);
        wait_done(0);
        rec_chk(32, 4, lut_v);
        wr(OFS_CMD, 32'h10);
        rd(OFS_CTRL, 32'h0, 32'h20);
        snap(32);
        wait_done(0);
        rec_chk(32, 1, 32'h0);
        rd(OFS_STATUS, 32'h0, 32'h20);
        $display("test correction done");
        wr(OFS_CTRL, 32'h0);
        wr(OFS_COUNT, 32'h8);
        repeat (3) done_q.push_back(8);
        wr(OFS_CMD, 32'h2);
        wait_done(1);
        wr(OFS_CMD, 32'h4);
        wait_done(0);
        repeat (12) @(posedge ref_clk);
        check("capturing", {31'h0, capturing}, 32'h0);
        rd(OFS_STATUS, 32'h0, 32'h11);
        $display("test continuous done");
        wr(OFS_CTRL, 32'hF);
        snap(8);
        repeat ($urandom_range(10, 3)) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h2, 32'h2);
        check("capturing", {31'h0, capturing}, 32'h0);
        event_in <= 1'b1;
        wait_done(0);
        rec_chk(8, 1, 32'h0);
        wr(OFS_CTRL, 32'h1);
        snap(8);
        event_in <= 1'b0;
        wait_done(0);
        wr(OFS_TIMEOUT, 32'h14);
        wr(OFS_CMD, 32'h1);
        repeat (30) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h8, 32'hB);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h1, 32'h3F);
        $display("test trigger done");
        wr(OFS_CMD, 32'h8);
        rd(OFS_CTRL, 32'h0, 32'h3F);
        rd(OFS_COUNT, 32'h100, 32'hFFFF_FFFF);
        $display("test defaults done");
        finish_test();
    end
endmodule : adc_capture_sequencer_test
`default_nettype wire

// *** tb/adc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_model
    import capture_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    output logic [SAMPLE_W-1:0] adc_data
);
    // A ramp: a dropped or doubled sample cannot hide
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adc_data <= 12'h000;
        end else begin
            adc_data <= adc_data + 12'h001;
        end
    end
endmodule : adc_model
`default_nettype wire
